/* rtl/cpwcfg_pkg.sv */
// constants for the configuration word and watchpoint registers.
// assumes a single core clock and the plain register port described in the top module.
package cpwcfg_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [4:0] IDX_SETUP = 5'h10;
  localparam logic [4:0] IDX_FWATCH = 5'h12;
  localparam logic [4:0] IDX_DATA_WATCHPOINT = 5'h13;
  localparam int ADDR_W = 7;
  // ---------------------------------------------------------------
  // setup word field positions and fixed values
  // ---------------------------------------------------------------
  localparam int EMU_BIT = 31;
  localparam int RATIO_LSB = 28;
  localparam int BYTE_ORDER_BIT = 15;
  localparam int ICACHE_LSB = 9;
  localparam int DCACHE_LSB = 6;
  localparam int ILINE_BIT = 5;
  localparam int DLINE_BIT = 4;
  localparam int MAP_DIS_BIT = 3;
  localparam logic [31:0] SETUP_FIXED = 32'h0002_6000;
  localparam logic [2:0] ICACHE_SIZE = 3'h4;
  localparam logic [2:0] DCACHE_SIZE = 3'h2;
  localparam logic LINE_16B = 1'b0;
  localparam logic [2:0] RATIO_RESERVED = 3'h7;
  localparam logic [2:0] POLICY_RESET = 3'h0;
  // ---------------------------------------------------------------
  // watch register field positions
  // ---------------------------------------------------------------
  localparam int FW_EN_BIT = 0;
  localparam int DW_STORE_BIT = 0;
  localparam int DW_LOAD_BIT = 1;
  localparam logic [31:0] FW_ADDR_MASK = 32'hffff_fffc;
  localparam logic [31:0] DW_ADDR_MASK = 32'hffff_fff8;
endpackage

/* rtl/cpwcfg_top.sv */
// configuration word and fetch/data watchpoints of the system coprocessor.
// assumes pipeline strobes are one-cycle pulses synchronous to ref_clk_i; the
// pipeline takes the watch exception in the cycle watch_take_o is high.
//
// Local design decision: the address-and-strobe port.
module cpwcfg_top #(
  parameter logic [2:0] RATIO_DEFAULT = 3'h0
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // hardware settings; straps sampled on the first clock after reset release, emulator_present_i on every clock
  input wire logic [2:0] core_clock_ratio_i,
  input wire logic byte_order_select_i,
  input wire logic onchip_map_disable_i,
  input wire logic emulator_present_i,
  // register port
  input wire logic [cpwcfg_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // fetch stage
  input wire logic fetch_valid_i,
  input wire logic [31:0] fetch_vaddr_i,
  input wire logic fetch_addr_err_i,
  // load/store stage
  input wire logic mem_valid_i,
  input wire logic mem_store_i,
  input wire logic mem_cache_op_i,
  input wire logic [31:0] mem_vaddr_i,
  input wire logic mem_addr_err_i,
  // status levels
  input wire logic exception_level_i,
  input wire logic error_level_i,
  // exception request and configuration outputs
  output logic watch_take_o,
  output logic watch_fetch_o,
  output logic watch_data_o,
  output logic [2:0] cached_seg_policy_o,
  output logic onchip_map_disable_o,
  output logic upper_map_onchip_o
);

  // ---------------------------------------------------------------
  // hardware settings, captured on the first clock after reset release (emulator bit on every clock)
  // ---------------------------------------------------------------
  logic rst_seen_ff;
  logic [2:0] ratio_ff, nxt_ratio;
  logic border_ff, nxt_border;
  logic mapdis_ff, nxt_mapdis;
  logic emu_ff, nxt_emu;

  // reset_n is asynchronous; the first clocked cycle after release loads straps
  always_comb begin
    nxt_ratio = rst_seen_ff ? ratio_ff : core_clock_ratio_i;
    nxt_border = rst_seen_ff ? border_ff : byte_order_select_i;
    nxt_mapdis = rst_seen_ff ? mapdis_ff : onchip_map_disable_i;
    nxt_emu = emulator_present_i;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_seen_ff <= 1'b0;
      ratio_ff <= RATIO_DEFAULT;
      border_ff <= 1'b0;
      mapdis_ff <= 1'b0;
      emu_ff <= 1'b0;
    end else begin
      rst_seen_ff <= 1'b1;
      ratio_ff <= nxt_ratio;
      border_ff <= nxt_border;
      mapdis_ff <= nxt_mapdis;
      emu_ff <= nxt_emu;
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  logic [2:0] policy_ff, nxt_policy;
  logic [29:0] fw_addr_ff, nxt_fw_addr;
  logic fw_en_ff, nxt_fw_en;
  logic [28:0] dw_addr_ff, nxt_dw_addr;
  logic dw_load_ff, nxt_dw_load;
  logic dw_store_ff, nxt_dw_store;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] setup_word;
  logic hit_setup, hit_fw, hit_dw;

  assign hit_setup = reg_addr_i == {cpwcfg_pkg::IDX_SETUP, 2'h0};
  assign hit_fw = reg_addr_i == {cpwcfg_pkg::IDX_FWATCH, 2'h0};
  assign hit_dw = reg_addr_i == {cpwcfg_pkg::IDX_DATA_WATCHPOINT, 2'h0};

  always_comb begin
    setup_word = cpwcfg_pkg::SETUP_FIXED;
    setup_word[cpwcfg_pkg::EMU_BIT] = emu_ff;
    setup_word[cpwcfg_pkg::RATIO_LSB +: 3] = ratio_ff;
    setup_word[cpwcfg_pkg::BYTE_ORDER_BIT] = border_ff;
    setup_word[cpwcfg_pkg::ICACHE_LSB +: 3] = cpwcfg_pkg::ICACHE_SIZE;
    setup_word[cpwcfg_pkg::DCACHE_LSB +: 3] = cpwcfg_pkg::DCACHE_SIZE;
    setup_word[cpwcfg_pkg::ILINE_BIT] = cpwcfg_pkg::LINE_16B;
    setup_word[cpwcfg_pkg::DLINE_BIT] = cpwcfg_pkg::LINE_16B;
    setup_word[cpwcfg_pkg::MAP_DIS_BIT] = mapdis_ff;
    setup_word[2:0] = policy_ff;
  end

  always_comb begin
    nxt_policy = policy_ff;
    nxt_fw_addr = fw_addr_ff;
    nxt_fw_en = fw_en_ff;
    nxt_dw_addr = dw_addr_ff;
    nxt_dw_load = dw_load_ff;
    nxt_dw_store = dw_store_ff;
    nxt_rdata = 32'h0000_0000;
    if (reg_wr_i) begin
      if (hit_setup) begin
        nxt_policy = reg_wdata_i[2:0];
      end
      if (hit_fw) begin
        nxt_fw_addr = reg_wdata_i[31:2];
        nxt_fw_en = reg_wdata_i[cpwcfg_pkg::FW_EN_BIT];
      end
      if (hit_dw) begin
        nxt_dw_addr = reg_wdata_i[31:3];
        nxt_dw_load = reg_wdata_i[cpwcfg_pkg::DW_LOAD_BIT];
        nxt_dw_store = reg_wdata_i[cpwcfg_pkg::DW_STORE_BIT];
      end
    end
    if (reg_rd_i) begin
      if (hit_setup) begin
        nxt_rdata = setup_word;
      end else if (hit_fw) begin
        nxt_rdata = {fw_addr_ff, 1'b0, fw_en_ff};
      end else if (hit_dw) begin
        nxt_rdata = {dw_addr_ff, 1'b0, dw_load_ff, dw_store_ff};
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      policy_ff <= cpwcfg_pkg::POLICY_RESET;
      fw_addr_ff <= 30'h0000_0000;
      fw_en_ff <= 1'b0;
      dw_addr_ff <= 29'h0000_0000;
      dw_load_ff <= 1'b0;
      dw_store_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      policy_ff <= nxt_policy;
      fw_addr_ff <= nxt_fw_addr;
      fw_en_ff <= nxt_fw_en;
      dw_addr_ff <= nxt_dw_addr;
      dw_load_ff <= nxt_dw_load;
      dw_store_ff <= nxt_dw_store;
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // watch match and postponement
  // ---------------------------------------------------------------
  logic fw_hit, dw_hit, levels_high;
  logic fpend_ff, nxt_fpend;
  logic dpend_ff, nxt_dpend;
  logic take_ff, nxt_take;
  logic tf_ff, nxt_tf;
  logic td_ff, nxt_td;
  logic map_on_ff, nxt_map_on;

  // virtual address compare; an address error outranks the watch
  assign fw_hit = fetch_valid_i && fw_en_ff && !fetch_addr_err_i
    && (fetch_vaddr_i[31:2] == fw_addr_ff);
  assign dw_hit = mem_valid_i && !mem_cache_op_i && !mem_addr_err_i
    && (mem_vaddr_i[31:3] == dw_addr_ff)
    && (mem_store_i ? dw_store_ff : dw_load_ff);
  assign levels_high = exception_level_i || error_level_i;

  always_comb begin
    nxt_fpend = fpend_ff;
    nxt_dpend = dpend_ff;
    nxt_take = 1'b0;
    nxt_tf = 1'b0;
    nxt_td = 1'b0;
    if (levels_high) begin
      nxt_fpend = fpend_ff || fw_hit;
      nxt_dpend = dpend_ff || dw_hit;
    end else if (fw_hit || dw_hit || fpend_ff || dpend_ff) begin
      nxt_take = 1'b1;
      nxt_tf = fw_hit || fpend_ff;
      nxt_td = dw_hit || dpend_ff;
      nxt_fpend = 1'b0;
      nxt_dpend = 1'b0;
    end
    nxt_map_on = !mapdis_ff;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fpend_ff <= 1'b0;
      dpend_ff <= 1'b0;
      take_ff <= 1'b0;
      tf_ff <= 1'b0;
      td_ff <= 1'b0;
      map_on_ff <= 1'b1;
    end else begin
      fpend_ff <= nxt_fpend;
      dpend_ff <= nxt_dpend;
      take_ff <= nxt_take;
      tf_ff <= nxt_tf;
      td_ff <= nxt_td;
      map_on_ff <= nxt_map_on;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign watch_take_o = take_ff;
  assign watch_fetch_o = tf_ff;
  assign watch_data_o = td_ff;
  assign cached_seg_policy_o = policy_ff;
  assign onchip_map_disable_o = mapdis_ff;
  assign upper_map_onchip_o = map_on_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_fetch_take;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (fw_hit && !levels_high) |=> (watch_take_o && watch_fetch_o);
  endproperty
  a_fetch_take: assert property (p_fetch_take) else $error("fetch watch not taken");

  property p_hold;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      levels_high |=> !watch_take_o;
  endproperty
  a_hold: assert property (p_hold) else $error("watch taken under raised level");

  property p_pend_release;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (fpend_ff && !levels_high) |=> (watch_take_o && watch_fetch_o && !fpend_ff);
  endproperty
  a_pend_release: assert property (p_pend_release) else $error("pending fetch lost");

  property p_load;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (mem_valid_i && !mem_store_i && !mem_cache_op_i && !mem_addr_err_i && dw_load_ff
       && mem_vaddr_i[31:3] == dw_addr_ff && !levels_high) |=> (watch_take_o && watch_data_o);
  endproperty
  a_load: assert property (p_load) else $error("load watch not taken");

  property p_store;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (mem_valid_i && mem_store_i && !dw_store_ff && !fw_hit && !fpend_ff && !dpend_ff)
      |=> !watch_take_o;
  endproperty
  a_store: assert property (p_store) else $error("disabled store watch fired");

  property p_cacheop;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (mem_valid_i && mem_cache_op_i && !fw_hit && !fpend_ff && !dpend_ff) |=> !watch_data_o;
  endproperty
  a_cacheop: assert property (p_cacheop) else $error("cache op raised watch");

  property p_ro;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (rst_seen_ff && reg_wr_i && hit_setup) |=> ($stable(ratio_ff) && $stable(border_ff));
  endproperty
  a_ro: assert property (p_ro) else $error("read-only setup bits changed");

  property p_setup_read;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (reg_rd_i && hit_setup) |=> (reg_rdata_o[11:4] == 8'h88 && reg_rdata_o[17:16] == 2'h2);
  endproperty
  a_setup_read: assert property (p_setup_read) else $error("setup fixed fields wrong");

  property p_fetch_err;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (fetch_valid_i && fetch_addr_err_i && !fpend_ff) |=> !watch_fetch_o;
  endproperty
  a_fetch_err: assert property (p_fetch_err) else $error("fetch watch beat address error");

  property p_data_err;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (mem_valid_i && mem_addr_err_i && !dpend_ff) |=> !watch_data_o;
  endproperty
  a_data_err: assert property (p_data_err) else $error("data watch beat address error");

  property p_store_take;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (mem_valid_i && mem_store_i && !mem_cache_op_i && !mem_addr_err_i && dw_store_ff
       && mem_vaddr_i[31:3] == dw_addr_ff && !levels_high) |=> (watch_take_o && watch_data_o);
  endproperty
  a_store_take: assert property (p_store_take) else $error("store watch not taken");

  property p_fetch_off;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (!fw_en_ff && !fpend_ff) |=> !watch_fetch_o;
  endproperty
  a_fetch_off: assert property (p_fetch_off) else $error("disabled fetch watch fired");

  property p_flags_take;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (watch_fetch_o || watch_data_o) |-> watch_take_o;
  endproperty
  a_flags_take: assert property (p_flags_take) else $error("cause flag without take");

  property p_fpend_set;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (fw_hit && levels_high) |=> fpend_ff;
  endproperty
  a_fpend_set: assert property (p_fpend_set) else $error("fetch match not held");

  property p_dpend_set;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (dw_hit && levels_high) |=> dpend_ff;
  endproperty
  a_dpend_set: assert property (p_dpend_set) else $error("data match not held");

  property p_dpend_release;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (dpend_ff && !levels_high) |=> (watch_take_o && watch_data_o && !dpend_ff);
  endproperty
  a_dpend_release: assert property (p_dpend_release) else $error("pending data lost");

  property p_policy_wr;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (reg_wr_i && hit_setup) |=> (cached_seg_policy_o == $past(reg_wdata_i[2:0]));
  endproperty
  a_policy_wr: assert property (p_policy_wr) else $error("policy field not written");

  property p_rdata_idle;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      !reg_rd_i |=> (reg_rdata_o == 32'h0000_0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

  property p_map_on;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (rst_seen_ff && $past(rst_seen_ff)) |-> (upper_map_onchip_o == !onchip_map_disable_o);
  endproperty
  a_map_on: assert property (p_map_on) else $error("upper map select wrong");

  property p_emu_read;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (reg_rd_i && hit_setup) |=> (reg_rdata_o[31] == $past(emu_ff));
  endproperty
  a_emu_read: assert property (p_emu_read) else $error("emulator bit wrong");

  property p_fixed_bits;
    @(posedge ref_clk_i) disable iff (!reset_n_i)
      (reg_rd_i && hit_setup) |=> (reg_rdata_o[27:18] == 10'h000 && reg_rdata_o[16] == 1'b0
       && reg_rdata_o[14:12] == 3'h6);
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("reserved setup bits wrong");
endmodule

/* testbench/cpwcfg_pipe_model.sv */
// fetch and load/store stages of the pipeline, as seen by the watch logic
// assumes the bench calls each task from one process; one access per stage per cycle
module cpwcfg_pipe_model (
  input wire logic clk_i,
  output logic fetch_valid_o,
  output logic [31:0] fetch_vaddr_o,
  output logic fetch_addr_err_o,
  output logic mem_valid_o,
  output logic mem_store_o,
  output logic mem_cache_op_o,
  output logic [31:0] mem_vaddr_o,
  output logic mem_addr_err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    fetch_valid_o = 1'b0;
    fetch_vaddr_o = 32'h0;
    fetch_addr_err_o = 1'b0;
    mem_valid_o = 1'b0;
    mem_store_o = 1'b0;
    mem_cache_op_o = 1'b0;
    mem_vaddr_o = 32'h0;
    mem_addr_err_o = 1'b0;
  end
  // released address lines show the inverse so stale values never match
  task automatic fetch(input logic [31:0] a, input logic err);
    @(posedge clk_i);
    fetch_valid_o <= 1'b1;
    fetch_vaddr_o <= a;
    fetch_addr_err_o <= err;
    @(posedge clk_i);
    fetch_valid_o <= 1'b0;
    fetch_vaddr_o <= ~a;
  endtask
  task automatic mem(input logic [31:0] a, input logic st, input logic co, input logic err);
    @(posedge clk_i);
    mem_valid_o <= 1'b1;
    mem_vaddr_o <= a;
    mem_store_o <= st;
    mem_cache_op_o <= co;
    mem_addr_err_o <= err;
    @(posedge clk_i);
    mem_valid_o <= 1'b0;
    mem_vaddr_o <= ~a;
  endtask
endmodule

/* testbench/tb_cp0_config_and_watchpoints.sv */
// self-checking bench for the configuration word and watchpoints
// assumes the register port answers reads one cycle later
module tb_cp0_config_and_watchpoints;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, bo, md, emu, wr, rd, exc_lvl, err_lvl;
  logic [2:0] ratio, r0, pol;
  logic b0, m0, take, wf, wd, map_dis, map_on;
  logic [6:0] addr;
  logic [31:0] wdata, rdata, d, fa, da;
  logic fv, fe, mv, ms, mc, me;
  logic [31:0] fad, mad;
  logic [1:0] last_fd;
  int n_mismatch = 0, checked = 0, n_take = 0, cyc = 0, t0;
  cpwcfg_top uut (.ref_clk_i(clk), .reset_n_i(rst_n), .core_clock_ratio_i(ratio),
    .byte_order_select_i(bo), .onchip_map_disable_i(md), .emulator_present_i(emu),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .fetch_valid_i(fv), .fetch_vaddr_i(fad), .fetch_addr_err_i(fe),
    .mem_valid_i(mv), .mem_store_i(ms), .mem_cache_op_i(mc), .mem_vaddr_i(mad),
    .mem_addr_err_i(me), .exception_level_i(exc_lvl), .error_level_i(err_lvl),
    .watch_take_o(take), .watch_fetch_o(wf), .watch_data_o(wd), .cached_seg_policy_o(pol),
    .onchip_map_disable_o(map_dis), .upper_map_onchip_o(map_on));
  cpwcfg_pipe_model pipe (.clk_i(clk), .fetch_valid_o(fv), .fetch_vaddr_o(fad),
    .fetch_addr_err_o(fe), .mem_valid_o(mv), .mem_store_o(ms), .mem_cache_op_o(mc),
    .mem_vaddr_o(mad), .mem_addr_err_o(me));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (take === 1'b1) begin
      n_take++;
      last_fd = {wf, wd};
    end
    if (cyc == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic close_out();
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // --------------------------------------------------------------
  // register port and watch helpers
  // --------------------------------------------------------------
  task automatic wr_reg(input logic [6:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [6:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk_take(input logic t, input logic f, input logic dd);
    #1;
    if (t)
      chk({29'h0, take, wf, wd}, {29'h0, t, f, dd});
    else
      chk({31'h0, take}, 32'h0);
  endtask
  function automatic logic [31:0] exp_setup(logic [2:0] r, logic b, logic m, logic e,
                                            logic [2:0] p);
    exp_setup = 32'h0002_6000 | {e, r, 28'h0} | (32'(b) << 15) | (32'h4 << 9)
                | (32'h2 << 6) | (32'(m) << 3) | 32'(p);
  endfunction
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    void'($urandom(11));
    {rst_n, emu, wr, rd, exc_lvl, err_lvl, addr, wdata} = '0;
    r0 = 3'($urandom_range(6, 0));
    b0 = 1'($urandom());
    m0 = 1'($urandom());
    {ratio, bo, md} = {r0, b0, m0};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(7'h40, d);
    chk(d, exp_setup(r0, b0, m0, 1'b0, 3'h0));
    chk({30'h0, map_dis, map_on}, {30'h0, m0, ~m0});
    rd_reg(7'h48, d);
    chk(d & 32'h1, 32'h0);
    rd_reg(7'h4c, d);
    chk(d & 32'h3, 32'h0);
    {ratio, bo, md} <= ~{r0, b0, m0};
    for (int p = 0; p < 8; p++) begin
      emu <= p[0];
      wr_reg(7'h40, exp_setup(~r0, ~b0, ~m0, ~p[0], 3'(p)));
      rd_reg(7'h40, d);
      chk(d, exp_setup(r0, b0, m0, p[0], 3'(p)));
      chk({29'h0, pol}, 32'(p));
    end
    rd_reg(7'h44, d);
    chk(d, 32'h0);
    fa = $urandom() & 32'hffff_fffc;
    da = $urandom() & 32'hffff_fff8;
    wr_reg(7'h48, fa | 32'h1);
    rd_reg(7'h48, d);
    chk(d, fa | 32'h1);
    pipe.fetch(fa | 32'h3, 1'b0);
    chk_take(1'b1, 1'b1, 1'b0);
    pipe.fetch(fa ^ 32'h4, 1'b0);
    chk_take(1'b0, 1'b0, 1'b0);
    pipe.fetch(fa, 1'b1);
    chk_take(1'b0, 1'b0, 1'b0);
    for (int e = 0; e < 4; e++) begin
      wr_reg(7'h4c, da | 32'(e));
      for (int s = 0; s < 2; s++) begin
        pipe.mem(da | 32'h5, s[0], 1'b0, 1'b0);
        chk_take(s ? e[0] : e[1], 1'b0, 1'b1);
      end
    end
    pipe.mem(da, 1'b0, 1'b1, 1'b0);
    chk_take(1'b0, 1'b0, 1'b0);
    pipe.mem(da, 1'b1, 1'b0, 1'b1);
    chk_take(1'b0, 1'b0, 1'b0);
    pipe.mem(da ^ 32'h8, 1'b0, 1'b0, 1'b0);
    chk_take(1'b0, 1'b0, 1'b0);
    fork
      pipe.fetch(fa, 1'b0);
      pipe.mem(da, 1'b1, 1'b0, 1'b0);
    join
    chk_take(1'b1, 1'b1, 1'b1);
    wr_reg(7'h48, fa);
    pipe.fetch(fa, 1'b0);
    chk_take(1'b0, 1'b0, 1'b0);
    wr_reg(7'h48, fa | 32'h1);
    {exc_lvl, err_lvl} <= 2'b11;
    pipe.fetch(fa, 1'b0);
    chk_take(1'b0, 1'b0, 1'b0);
    @(posedge clk) exc_lvl <= 1'b0;
    t0 = n_take;
    repeat (4) @(posedge clk);
    chk(32'(n_take - t0), 32'h0);
    err_lvl <= 1'b0;
    repeat (5) @(posedge clk);
    chk(32'(n_take - t0), 32'h1);
    chk({30'h0, last_fd}, 32'h2);
    close_out();
  end
endmodule
